// ---- irc_baud_gen.sv ----
// Baud tick generator: one clock-wide tick per divisor count
module irc_baud_gen
    import irc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    irc_baud_if.gen bif
);
    logic [15:0] cnt_r;
    logic tick_r;

    // ----------------------------------------------------------------
    // Down counter
    // ----------------------------------------------------------------
    // one tick per divisor count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= DIV_ONE;
        end else if (cnt_r <= DIV_ONE) begin
            cnt_r <= bif.divisor;
        end else begin
            cnt_r <= cnt_r - DIV_ONE;
        end
    end

    // tick rate is clock over divisor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r <= DIV_ONE);
        end
    end

    assign bif.tick = tick_r;

    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        (tick_r && bif.divisor > DIV_ONE && $stable(bif.divisor)) |=> !tick_r)
        else $error("baud tick repeated too soon");
endmodule

// ---- irc_baud_if.sv ----
// Divisor and baud tick between the codec and its tick generator
interface irc_baud_if;
    logic [15:0] divisor;
    logic tick;
    modport gen (input divisor, output tick);
    modport user (output divisor, input tick);
endinterface

// ---- irc_codec.sv ----
// Infrared symbol encoder and decoder between a UART and an IR transceiver
// --------------------------------------------------------------------
// Notes on behaviour
// - Bit rate equals system clock over sixteen times the divisor.
// - Divisor is high byte joined with low byte, sixteen bits.
// - Enable bit routes UART traffic through the codec, else pins direct.
// - Enabled: UART output stays inside, encoded signal drives transmit pin.
// - Enabled: receive pin is decoded and fed to the UART input.
// - No receive starts or resyncs while transmitting; a transmit may start while the decoder runs.
// - Every coded bit lasts sixteen baud ticks both ways.
// - A one bit keeps the output low all sixteen ticks.
// - A zero bit is seven low, three high, six low ticks.
// - Decoder counts zero to fifteen, cleared on a falling edge taken while idle or with the window open.
// - Decoded bit reaches the UART at count eight, eight ticks late.
// - Window opens at count twelve, stays open until count eight.
// - Pulse in window decodes zero; none decodes one and idles.
// - Resynchronising the decoder never disturbs the UART receiver.
// --------------------------------------------------------------------
//
// Strobed register access is this design's own decision.
module irc_codec
    import irc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [irc_pkg::ADDR_W-1:0] ADDR,
    input wire logic [irc_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [irc_pkg::DATA_W-1:0] RDATA,
    input wire logic [irc_pkg::DATA_W-1:0] DIV_HIGH,
    input wire logic UART_TXD,
    output logic UART_RXD,
    output logic TXD_PIN,
    input wire logic RXD_PIN,
    output logic RX_BIT_DATA,
    output logic RX_BIT_VALID,
    input wire logic RX_BIT_READY
);
    import irc_pkg::*;

    function automatic logic [3:0] cnt_inc(input logic [3:0] c);
        cnt_inc = c + 4'h1;
    endfunction

    function automatic logic in_pulse(input logic [3:0] c);
        in_pulse = (c >= ENC_HIGH_FIRST) && (c <= ENC_HIGH_LAST);
    endfunction

    logic [7:0] div_low_r;
    logic en_r;
    logic ovr_r;
    logic [7:0] rdata_r;
    logic tick;
    irc_enc_state_t enc_state_r;
    logic [3:0] enc_cnt_r;
    logic enc_bit_r;
    logic ir_out_r;
    logic tx_busy;
    irc_dec_state_t dec_state_r;
    logic [3:0] dec_cnt_r;
    logic [3:0] dec_cnt_nxt;
    logic dec_win_r;
    logic dec_rxd_r;
    logic rx_prev_r;
    logic fall;
    logic fall_take;
    logic dec_push;
    logic dec_run;
    logic fifo_mem_r [0:1];
    logic fifo_wp_r;
    logic fifo_rp_r;
    logic [1:0] fifo_cnt_r;
    logic fifo_in_ready;
    logic fifo_pop;
    logic fifo_push;

    // ----------------------------------------------------------------
    // Baud tick generator
    // ----------------------------------------------------------------
    irc_baud_if bif ();

    assign bif.divisor = {DIV_HIGH, div_low_r};
    assign tick = bif.tick;

    irc_baud_gen u_baud (
        .clk (CLK),
        .rst_n (RST_N),
        .bif (bif)
    );

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_low_r <= DIV_LOW_RST;
        end else if (WR && ADDR == ADDR_DIV_LOW) begin
            div_low_r <= WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_r <= 1'b0;
        end else if (WR && ADDR == ADDR_CTRL) begin
            en_r <= WDATA[CTRL_EN_BIT];
        end
    end

    // Overrun flag: a new loss wins over a clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovr_r <= 1'b0;
        end else if (dec_push && !fifo_in_ready) begin
            ovr_r <= 1'b1;
        end else if (WR && ADDR == ADDR_STATUS && WDATA[STAT_OVR_BIT]) begin
            ovr_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_r <= DATA_ZERO;
        end else if (RD) begin
            case (ADDR)
                ADDR_DIV_LOW: rdata_r <= div_low_r;
                ADDR_CTRL: begin
                    rdata_r <= DATA_ZERO;
                    rdata_r[CTRL_EN_BIT] <= en_r;
                end
                ADDR_STATUS: begin
                    rdata_r <= DATA_ZERO;
                    rdata_r[STAT_TX_BUSY_BIT] <= tx_busy;
                    rdata_r[STAT_RX_RUN_BIT] <= dec_run;
                    rdata_r[STAT_RXD_BIT] <= dec_rxd_r;
                    rdata_r[STAT_OVR_BIT] <= ovr_r;
                    rdata_r[STAT_FILL_LSB +: 2] <= fifo_cnt_r;
                end
                default: rdata_r <= DATA_ZERO;
            endcase
        end else begin
            rdata_r <= DATA_ZERO;
        end
    end

    assign RDATA = rdata_r;

    // ----------------------------------------------------------------
    // Encoder
    // ----------------------------------------------------------------
    // sixteen ticks per transmitted bit
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            enc_state_r <= IRC_ENC_IDLE;
            enc_cnt_r <= CNT_ZERO;
            enc_bit_r <= 1'b1;
        end else if (!en_r) begin
            enc_state_r <= IRC_ENC_IDLE;
            enc_cnt_r <= CNT_ZERO;
            enc_bit_r <= 1'b1;
        end else if (tick) begin
            case (enc_state_r)
                IRC_ENC_IDLE: begin
                    if (!UART_TXD) begin
                        enc_state_r <= IRC_ENC_RUN;
                        enc_cnt_r <= CNT_ZERO;
                        enc_bit_r <= 1'b0;
                    end
                end
                IRC_ENC_RUN: begin
                    enc_cnt_r <= cnt_inc(enc_cnt_r);
                    if (enc_cnt_r == CNT_LAST) begin
                        enc_bit_r <= UART_TXD;
                        if (UART_TXD) begin
                            enc_state_r <= IRC_ENC_IDLE;
                        end
                    end
                end
                default: enc_state_r <= IRC_ENC_IDLE;
            endcase
        end
    end

    assign tx_busy = (enc_state_r == IRC_ENC_RUN);

    // zero bit pulses high in ticks seven to nine
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ir_out_r <= 1'b0;
        end else begin
            ir_out_r <= tx_busy && !enc_bit_r && in_pulse(enc_cnt_r);
        end
    end

    // encoded signal drives the transmit pin when enabled, else UART_TXD does
    assign TXD_PIN = en_r ? ir_out_r : UART_TXD;

    // ----------------------------------------------------------------
    // Decoder
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_prev_r <= 1'b0;
        end else begin
            rx_prev_r <= RXD_PIN;
        end
    end

    assign fall = en_r && !tx_busy && rx_prev_r && !RXD_PIN;
    assign dec_run = (dec_state_r == IRC_DEC_RUN);
    assign fall_take = fall && (!dec_run || dec_win_r);
    assign dec_cnt_nxt = cnt_inc(dec_cnt_r);
    assign dec_push = dec_run && !fall_take && tick && dec_cnt_nxt == DEC_UPDATE;

    // counter cleared on a falling edge taken while idle or with the window open
    // window opens at twelve, closes at eight
    // no pulse in window means idle again
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dec_state_r <= IRC_DEC_IDLE;
            dec_cnt_r <= CNT_ZERO;
            dec_win_r <= 1'b0;
        end else if (!en_r) begin
            dec_state_r <= IRC_DEC_IDLE;
            dec_cnt_r <= CNT_ZERO;
            dec_win_r <= 1'b0;
        end else if (fall_take) begin
            dec_state_r <= IRC_DEC_RUN;
            dec_cnt_r <= CNT_ZERO;
            dec_win_r <= 1'b0;
        end else if (dec_run && tick) begin
            dec_cnt_r <= dec_cnt_nxt;
            if (dec_cnt_nxt == DEC_WIN_OPEN) begin
                dec_win_r <= 1'b1;
            end else if (dec_cnt_nxt == DEC_UPDATE && dec_win_r) begin
                dec_state_r <= IRC_DEC_IDLE;
                dec_win_r <= 1'b0;
            end
        end
    end

    // decoded bit updated at count eight
    // idle line stays one between bits
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dec_rxd_r <= 1'b1;
        end else if (!en_r) begin
            dec_rxd_r <= 1'b1;
        end else if (dec_push) begin
            dec_rxd_r <= dec_win_r;
        end
    end

    // decoded stream feeds the UART input when enabled, else RXD_PIN does
    assign UART_RXD = en_r ? dec_rxd_r : RXD_PIN;

    // ----------------------------------------------------------------
    // Decoded bit buffer
    // ----------------------------------------------------------------
    assign fifo_in_ready = (fifo_cnt_r != FIFO_DEPTH);
    assign fifo_push = dec_push && fifo_in_ready;
    assign fifo_pop = RX_BIT_VALID && RX_BIT_READY;
    assign RX_BIT_VALID = (fifo_cnt_r != FIFO_NONE);
    assign RX_BIT_DATA = fifo_mem_r[fifo_rp_r];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fifo_mem_r[0] <= 1'b1;
            fifo_mem_r[1] <= 1'b1;
        end else if (fifo_push) begin
            fifo_mem_r[fifo_wp_r] <= dec_win_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fifo_wp_r <= 1'b0;
            fifo_rp_r <= 1'b0;
            fifo_cnt_r <= FIFO_NONE;
        end else begin
            if (fifo_push) begin
                fifo_wp_r <= !fifo_wp_r;
            end
            if (fifo_pop) begin
                fifo_rp_r <= !fifo_rp_r;
            end
            if (fifo_push && !fifo_pop) begin
                fifo_cnt_r <= fifo_cnt_r + 2'h1;
            end else if (fifo_pop && !fifo_push) begin
                fifo_cnt_r <= fifo_cnt_r - 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_edge_taken;
        fall_take;
    endsequence

    sequence s_zero_pulse;
        tx_busy && !enc_bit_r && in_pulse(enc_cnt_r);
    endsequence

    a_pulse_shape: assert property (s_zero_pulse |=> ir_out_r)
        else $error("zero bit pulse missing");
    a_one_low: assert property (enc_bit_r |=> !ir_out_r)
        else $error("one bit not low");
    a_pulse_bounds: assert property ($rose(ir_out_r) |-> $past(enc_cnt_r) == ENC_HIGH_FIRST)
        else $error("pulse starts at wrong tick");
    a_tx_bypass: assert property (!en_r |-> TXD_PIN == UART_TXD)
        else $error("bypass broken");
    a_tx_route: assert property (en_r |-> TXD_PIN == ir_out_r)
        else $error("transmit pin not from encoder");
    a_rx_route: assert property (en_r |-> UART_RXD == dec_rxd_r)
        else $error("uart input not decoded");
    a_cnt_clear: assert property (s_edge_taken |=> dec_cnt_r == CNT_ZERO && dec_run)
        else $error("edge did not clear counter");
    a_rxd_lag: assert property ($changed(dec_rxd_r) && $past(en_r) && en_r
        |-> dec_cnt_r == DEC_UPDATE)
        else $error("decoded bit changed off count eight");
    a_win_open: assert property ($rose(dec_win_r) |-> dec_cnt_r == DEC_WIN_OPEN)
        else $error("window opened at wrong count");
    a_half_duplex: assert property ((tx_busy && !dec_run) |=> !dec_run)
        else $error("decoder started while transmitting");
    a_fifo_bound: assert property (fifo_cnt_r <= FIFO_DEPTH)
        else $error("buffer count out of range");
endmodule

// ---- irc_pkg.sv ----
// Constants, register map and types shared by the infrared codec files
package irc_pkg;
    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] ADDR_DIV_LOW = 12'hf47;
    localparam logic [11:0] ADDR_CTRL = 12'hf48;
    localparam logic [11:0] ADDR_STATUS = 12'hf49;
    localparam logic [7:0] DIV_LOW_RST = 8'h01;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_TX_BUSY_BIT = 0;
    localparam int STAT_RX_RUN_BIT = 1;
    localparam int STAT_RXD_BIT = 2;
    localparam int STAT_OVR_BIT = 3;
    localparam int STAT_FILL_LSB = 4;
    // ----------------------------------------------------------------
    // Baud divisor and symbol timing in baud ticks
    // ----------------------------------------------------------------
    localparam int DIV_W = 16;
    localparam logic [15:0] DIV_ONE = 16'h0001;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_LAST = 4'hf;
    localparam logic [3:0] ENC_HIGH_FIRST = 4'h7;
    localparam logic [3:0] ENC_HIGH_LAST = 4'h9;
    localparam logic [3:0] DEC_UPDATE = 4'h8;
    localparam logic [3:0] DEC_WIN_OPEN = 4'hc;
    // ----------------------------------------------------------------
    // Decoded bit buffer
    // ----------------------------------------------------------------
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [1:0] FIFO_NONE = 2'h0;
    typedef enum logic {IRC_ENC_IDLE, IRC_ENC_RUN} irc_enc_state_t;
    typedef enum logic {IRC_DEC_IDLE, IRC_DEC_RUN} irc_dec_state_t;
endpackage

// ---- irc_xcvr_model.sv ----
// Infrared transceiver model: photodiode pulses toward the codec
module irc_xcvr_model (
    input wire logic clk,
    input wire logic led_in,
    output logic pd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int led_pulses = 0;
    initial pd_out = 1'b0;

    always @(posedge led_in) begin
        led_pulses++;
    end

    // Static level on the photodiode line
    task automatic set_level(input logic v);
        @(posedge clk);
        pd_out <= v;
    endtask

    task automatic send_bits(input logic [7:0] bits, input int n, input int tclk, input int early);
        int pre;
        for (int i = 0; i < n; i++) begin
            pre = (i == early) ? 4 : 7;
            repeat (pre * tclk) @(posedge clk);
            pd_out <= ~bits[i];
            repeat (3 * tclk) @(posedge clk);
            pd_out <= 1'b0;
            repeat ((13 - pre) * tclk) @(posedge clk);
        end
    endtask
endmodule

// ---- tb_irc_codec.sv ----
// Self-checking bench for the infrared codec
module tb_irc_codec;
    timeunit 1ns;
    timeprecision 1ps;
    import irc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 12'h000;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] div_high = 8'h00;
    logic uart_txd = 1'b1;
    logic uart_rxd;
    logic txd_pin;
    logic rxd_pin;
    logic rx_data;
    logic rx_valid;
    logic rx_ready = 1'b1;
    int mismatches = 0;
    int check_count = 0;
    int led_base;
    logic got[$];

    always #10 clk = ~clk;

    irc_codec i_irc_codec (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .DIV_HIGH(div_high), .UART_TXD(uart_txd), .UART_RXD(uart_rxd),
        .TXD_PIN(txd_pin), .RXD_PIN(rxd_pin), .RX_BIT_DATA(rx_data),
        .RX_BIT_VALID(rx_valid), .RX_BIT_READY(rx_ready)
    );

    irc_xcvr_model i_irc_xcvr_model (.clk(clk), .led_in(txd_pin), .pd_out(rxd_pin));

    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            got.push_back(rx_data);
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        mismatches++;
        $display("wrong value %s expected event seen timeout", what);
        complete_run();
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(what, 16'(rdata), 16'(exp));
    endtask

    task automatic wait_for(ref logic s, input logic val, input int lim, input string what);
        for (int i = 0; i <= lim; i++) begin
            @(negedge clk);
            if (s === val) begin
                return;
            end
        end
        timeout(what);
    endtask

    task automatic count_while(ref logic s, input logic val, input int lim, output int c);
        c = 0;
        while (s === val) begin
            c++;
            if (c > lim) begin
                timeout("level length");
            end
            @(negedge clk);
        end
    endtask

    task automatic tx_check(input logic [7:0] lo, input logic [7:0] hi);
        int d;
        int c;
        d = (int'(hi) * 256) + int'(lo);
        reg_wr(ADDR_DIV_LOW, lo);
        div_high <= hi;
        uart_txd <= 1'b0;
        wait_for(txd_pin, 1'b1, 20 * d + 300, "pulse start");
        count_while(txd_pin, 1'b1, 20 * d, c);
        check("pulse width", 16'(c), 16'(3 * d));
        count_while(txd_pin, 1'b0, 20 * d, c);
        check("pulse gap", 16'(c), 16'(13 * d));
        @(posedge clk);
        uart_txd <= 1'b1;
        count_while(txd_pin, 1'b1, 20 * d, c);
        c = 0;
        repeat (20 * d) begin
            @(negedge clk);
            if (txd_pin !== 1'b0) begin
                c++;
            end
        end
        check("one bit low", 16'(c), 16'h0000);
    endtask

    task automatic rx_check(input logic [7:0] bits, input int n, input int early,
                            input logic [7:0] exp, input int m);
        got.delete();
        i_irc_xcvr_model.send_bits(bits, n, 1, early);
        repeat (40) @(posedge clk);
        check("decoded count", 16'(got.size()), 16'(m));
        for (int i = 0; i < m && i < got.size(); i++) begin
            check("decoded bit", 16'(got[i]), 16'(exp[i]));
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_DIV_LOW, DIV_LOW_RST, "divisor reset");
        reg_wr(ADDR_DIV_LOW, 8'ha5);
        reg_wr(12'hf4a, 8'hff);
        rd_chk(ADDR_DIV_LOW, 8'ha5, "divisor rw");
        rd_chk(12'hf4a, DATA_ZERO, "unmapped");
        for (int v = 0; v < 2; v++) begin
            i_irc_xcvr_model.set_level(v[0]);
            uart_txd <= v[0];
            @(negedge clk);
            check("tx bypass", 16'(txd_pin), 16'(v));
            check("rx bypass", 16'(uart_rxd), 16'(v));
        end
        i_irc_xcvr_model.set_level(1'b0);
        reg_wr(ADDR_CTRL, 8'h01);
        rd_chk(ADDR_CTRL, 8'h01, "enable rw");
        @(negedge clk);
        check("tx internal", 16'(txd_pin), 16'h0000);
        check("rx decoded", 16'(uart_rxd), 16'h0001);
        led_base = i_irc_xcvr_model.led_pulses;
        tx_check(8'h03, 8'h00);
        tx_check(8'h00, 8'h01);
        tx_check(8'h01, 8'h00);
        check("led pulses", 16'(i_irc_xcvr_model.led_pulses - led_base), 16'h0006);
        fork
            i_irc_xcvr_model.send_bits(8'h00, 1, 1, -1);
            begin
                wait_for(rxd_pin, 1'b1, 40, "rx pulse");
                wait_for(rxd_pin, 1'b0, 10, "rx fall");
                repeat (7) @(negedge clk);
                check("early rx", 16'(uart_rxd), 16'h0001);
                repeat (4) @(negedge clk);
                check("late rx", 16'(uart_rxd), 16'h0000);
            end
        join
        repeat (40) @(posedge clk);
        rx_check(8'h04, 4, 1, 8'h14, 5);
        rx_check(8'h00, 2, 1, 8'h04, 3);
        rx_ready <= 1'b0;
        i_irc_xcvr_model.send_bits(8'h00, 4, 1, -1);
        repeat (40) @(posedge clk);
        rd_chk(ADDR_STATUS, 8'h2c, "status full");
        reg_wr(ADDR_STATUS, 8'h08);
        rd_chk(ADDR_STATUS, 8'h24, "overrun clear");
        got.delete();
        @(posedge clk);
        rx_ready <= 1'b1;
        repeat (4) @(posedge clk);
        check("drained", 16'(got.size()), 16'h0002);
        check("drain valid", 16'(rx_valid), 16'h0000);
        got.delete();
        uart_txd <= 1'b0;
        i_irc_xcvr_model.send_bits(8'h00, 1, 1, -1);
        uart_txd <= 1'b1;
        repeat (60) @(posedge clk);
        check("half duplex", 16'(got.size()), 16'h0000);
        complete_run();
    end
endmodule
